/* gptc_consts.svh */
// Purpose: constants for the core timer control block of the first timer block
// Assumes: 40 MHz module clock, Avalon-MM register access, 32-bit words
// Notes:   register offsets are byte addresses of aligned words
// Overview of operation
// - three 16-bit up/down counters, software read/write
// - one core, two auxiliary timers, four modes
// - finest count tick is module clock/4
// - module count clock comes from bus clock
// - cpu count write beats count/reload/capture
// - core counts only while run bit set
// - gated mode needs run and active gate
// - remote run bit lets core run drive aux
// - gate/count pin gates or counts per mode
// - direction from software bit when ext off, outside encoder modes
// - ext pin sets direction, software bit inverts
// - direction change works running or stopped
// - core over/underflow toggles latch and shadow
// - shadow lags one cycle, mismatch triggers aux
// - software latch write sets both, no trigger
// - output pin shows latch or idles high
// - trigger counts aux or reloads core
// - aux concatenates, captures or reloads core
// - interrupts handled outside, single shared node
// - mode codes 000 timer 001 counter 01x gated 11x encoder
// - code 010 gate low, 011 gate high
`ifndef GPTC_CONSTS_SVH
`define GPTC_CONSTS_SVH
`define GPTC_OFS_CORE_CTRL  4'h0
`define GPTC_OFS_AUX_A_CTRL 4'h4
`define GPTC_OFS_AUX_B_CTRL 4'h8
`define GPTC_OFS_CORE_CNT   4'hC
`define GPTC_IDX_CORE       2'h1
`define GPTC_IDX_AUX_A      2'h0
`define GPTC_IDX_AUX_B      2'h2
`define GPTC_PRESCALE       2'h3
`define GPTC_CNT_MAX        16'hFFFF
`define GPTC_CNT_ZERO       16'h0000
`define GPTC_CTRL_RESET     12'h000
`endif

/* gptc_pkg.sv */
// Purpose: types shared by the timer control block
// Assumes: gptc_consts.svh constants
// Notes:   control word is 12 bits, low bits of a bus word
`default_nettype none
package gptc_pkg;
  typedef enum logic [2:0] {
    GPTC_TIMER     = 3'b000,
    GPTC_COUNTER   = 3'b001,
    GPTC_GATE_LOW  = 3'b010,
    GPTC_GATE_HIGH = 3'b011,
    GPTC_RSV4      = 3'b100,
    GPTC_RSV5      = 3'b101,
    GPTC_ENC_ROT   = 3'b110,
    GPTC_ENC_EDGE  = 3'b111
  } gptc_mode_type;
  // aux function select: 00 own modes, 01 concat, 10 reload, 11 capture
  typedef struct packed {
    logic [1:0]    aux_func;
    logic          remote_run;
    logic          toggle_oe;
    logic          toggle_latch;
    logic          ext_dir_en;
    logic          sw_dir;
    logic          run;
    logic [1:0]    edge_sel;
    logic          rsv;
    logic          mode_msb;
  } gptc_ctrl_type;
  typedef struct packed {
    logic gate_count;
    logic ext_updown;
  } gptc_pins_type;
endpackage : gptc_pkg
`default_nettype wire

/* gptc_counter.sv */
// Purpose: one 16-bit up/down counter with a priority cpu load port
// Assumes: step, dir and load from same clock domain
// Notes:   load beats any step in the same cycle
`default_nettype none
module gptc_counter #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             step,
  input  wire logic             dir_down,
  // state
  output logic      [WIDTH-1:0] count_q,
  output logic                  wrap
);
  // wrap marks the step that passes max or zero
  assign wrap = step && !load &&
                (dir_down ? (count_q == '0) : (count_q == '1));
  // count register, a load always wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_val;
    end else if (step) begin
      count_q <= dir_down ? count_q - 1'b1 : count_q + 1'b1;
    end
  end
endmodule // gptc_counter
`default_nettype wire

/* gptc_core.sv */
// Purpose: core timer plus two aux timers, run, direction and toggle latch
// Assumes: avalon-mm slave, word aligned, 40 MHz clk_sys as module clock
// Notes:   pins pass two flip-flops; interrupts live outside this block
`include "gptc_consts.svh"
`default_nettype none
module gptc_core
  import gptc_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // avalon-mm slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  output logic      [1:0]           avs_response,
  // pins, index 0 aux a, 1 core, 2 aux b
  input  wire gptc_pkg::gptc_pins_type pins [3],
  output logic                      toggle_output_pin,
  output logic                      aux_a_trigger,
  output logic                      aux_b_trigger
);
  import gptc_pkg::*;

  logic                rst_q1, rst_n_q;
  logic [1:0]          pin_s1 [3];
  logic [1:0]          pin_s2 [3];
  logic [1:0]          pin_old_q [3];
  logic [1:0]          presc_q;
  logic                tick;
  gptc_ctrl_type       ctrl_q [3];
  logic [15:0]         aux_cnt [3];
  logic                load [3];
  logic [15:0]         load_val [3];
  logic                step [3];
  logic                dir_down [3];
  logic                wrap [3];
  logic                shadow_q;
  logic                trig;
  logic                rd_ack_q;
  logic                wr_hit;
  logic                ctrl_wr [3];
  logic                cnt_wr [3];
  logic                cnt_core_reload;
  logic [15:0]         reload_src;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_q1  <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_q1  <= 1'b1;
      rst_n_q <= rst_q1;
    end
  end

  // pin synchronisers: first stage read only by second stage
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < 3; i++) begin
        pin_s1[i]    <= 2'h0;
        pin_s2[i]    <= 2'h0;
        pin_old_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        pin_s1[i]    <= {pins[i].gate_count, pins[i].ext_updown};
        pin_s2[i]    <= pin_s1[i];
        pin_old_q[i] <= pin_s2[i];
      end
    end
  end

  // module count tick every fourth clock, the finest resolution
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      presc_q <= 2'h0;
    end else begin
      presc_q <= presc_q + 2'h1;
    end
  end
  assign tick = (presc_q == `GPTC_PRESCALE);

  // register index of a word address, used for control and count
  function automatic logic [1:0] reg_idx(input logic [3:0] a);
    case (a)
      `GPTC_OFS_AUX_A_CTRL: reg_idx = `GPTC_IDX_AUX_A;
      `GPTC_OFS_AUX_B_CTRL: reg_idx = `GPTC_IDX_AUX_B;
      default:              reg_idx = `GPTC_IDX_CORE;
    endcase
  endfunction

  // count windows sit at offset 0x10 upward would exceed 4 bits,
  // so counts share the upper half-word of each control word
  assign wr_hit = avs_write && (avs_address[1:0] == 2'h0) && (avs_address != `GPTC_OFS_CORE_CNT);

  // write strobes: low bytes hit control, high bytes hit count
  generate
    for (genvar g = 0; g < 3; g++) begin : g_wr
      assign ctrl_wr[g] = wr_hit && (reg_idx(avs_address) == 2'(g)) &&
                          avs_byteenable[1];
      assign cnt_wr[g]  = wr_hit && (reg_idx(avs_address) == 2'(g)) &&
                          (avs_byteenable[3:2] == 2'h3);
    end
  endgenerate

  // writes finish at once; reads take one wait cycle for registered data
  assign avs_waitrequest = avs_read && !rd_ack_q;
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_ack_q     <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else begin
      rd_ack_q <= avs_read && !rd_ack_q;
      if (avs_read && !rd_ack_q) begin
        if (avs_address[1:0] != 2'h0 || avs_address == `GPTC_OFS_CORE_CNT) begin
          avs_readdata <= 32'h0000_0000;
          avs_response <= 2'h2; // unmapped: slave error
        end else begin
          avs_readdata <= {aux_cnt[reg_idx(avs_address)], 4'h0,
                           ctrl_q[reg_idx(avs_address)]};
          avs_response <= 2'h0;
        end
      end
    end
  end

  // control registers; hardware toggles the core latch on wrap
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < 3; i++) begin
        ctrl_q[i] <= `GPTC_CTRL_RESET;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ctrl_wr[i]) begin
          ctrl_q[i] <= avs_writedata[11:0];
        end
      end
      if (ctrl_wr[1]) begin
        ctrl_q[1].toggle_latch <= avs_writedata[7];
      end else if (wrap[1]) begin
        ctrl_q[1].toggle_latch <= !ctrl_q[1].toggle_latch;
      end
    end
  end

  // shadow latch lags one cycle; a software write moves both together
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shadow_q <= 1'b0;
    end else if (ctrl_wr[1]) begin
      shadow_q <= avs_writedata[7];
    end else begin
      shadow_q <= ctrl_q[1].toggle_latch;
    end
  end
  assign trig = (shadow_q != ctrl_q[1].toggle_latch);

  // output pin shows latch, idles high when disabled
  assign toggle_output_pin = ctrl_q[1].toggle_oe ? ctrl_q[1].toggle_latch : 1'b1;

  // per-timer run, gate, event and direction logic
  generate
    for (genvar g = 0; g < 3; g++) begin : g_tmr
      gptc_mode_type mode;
      logic          run, gate_ok, pin_edge, enc_edge, enc_down, func_own;
      assign mode = gptc_mode_type'({ctrl_q[g].mode_msb, ctrl_q[g].edge_sel[1],
                                     ctrl_q[g].rsv});
      // aux run follows core run when remote run is set
      assign run  = (g != 1 && ctrl_q[g].remote_run) ? ctrl_q[1].run
                                                     : ctrl_q[g].run;
      assign gate_ok = (mode == GPTC_GATE_HIGH) ? pin_s2[g][1]
                                                : !pin_s2[g][1];
      assign pin_edge = (pin_s2[g][1] != pin_old_q[g][1]) &&
                        (ctrl_q[g].edge_sel[0] ? !pin_s2[g][1] : pin_s2[g][1]);
      // encoder: direction from the other input's level
      assign enc_edge = (pin_s2[g] != pin_old_q[g]);
      assign enc_down = (pin_s2[g][1] != pin_old_q[g][1]) ?
                        (pin_s2[g][1] == pin_s2[g][0]) :
                        (pin_s2[g][0] != pin_s2[g][1]);
      assign func_own = (g == 1) || (ctrl_q[g].aux_func == 2'h0);
      // direction: encoder or ext pin xor software bit, else software bit alone, running or not
      always_comb begin
        if (mode == GPTC_ENC_ROT || mode == GPTC_ENC_EDGE) begin
          dir_down[g] = enc_down ^ ctrl_q[g].sw_dir;
        end else if (ctrl_q[g].ext_dir_en) begin
          dir_down[g] = pin_s2[g][0] ^ ctrl_q[g].sw_dir;
        end else begin
          dir_down[g] = ctrl_q[g].sw_dir;
        end
      end
      // count event per mode
      always_comb begin
        step[g] = 1'b0;
        if (!func_own) begin
          step[g] = run && (ctrl_q[g].aux_func == 2'h1) && trig;
        end else begin
          case (mode)
            GPTC_TIMER:     step[g] = run && tick;
            GPTC_COUNTER:   step[g] = run && pin_edge;
            GPTC_GATE_LOW,
            GPTC_GATE_HIGH: step[g] = run && gate_ok && tick;
            GPTC_ENC_ROT,
            GPTC_ENC_EDGE:  step[g] = run && enc_edge;
            default:        step[g] = 1'b0;
          endcase
        end
      end
      // load: cpu write first, then reload or capture
      always_comb begin
        load[g]     = cnt_wr[g];
        load_val[g] = avs_writedata[31:16];
        if (!cnt_wr[g] && g != 1) begin
          if (ctrl_q[g].aux_func == 2'h3 && pin_edge) begin
            load[g]     = 1'b1;
            load_val[g] = aux_cnt[1];
          end
        end
      end
      gptc_counter #(.WIDTH(16)) u_cnt (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n_q),
        .load     (load[g] || (g == 1 && cnt_core_reload)),
        .load_val ((g == 1 && !cnt_wr[1]) ? reload_src : load_val[g]),
        .step     (step[g]),
        .dir_down (dir_down[g]),
        .count_q  (aux_cnt[g]),
        .wrap     (wrap[g])
      );
    end
  endgenerate

  // core reload from an aux set to reload on a latch trigger
  assign cnt_core_reload = trig && !cnt_wr[1] &&
                           ((ctrl_q[0].aux_func == 2'h2) ||
                            (ctrl_q[2].aux_func == 2'h2));
  assign reload_src = (ctrl_q[0].aux_func == 2'h2) ? aux_cnt[0] : aux_cnt[2];

  // trigger lines to the aux timers; no interrupt flag is kept in here
  assign aux_a_trigger = trig;
  assign aux_b_trigger = trig;

  // toggle latch flips one clock after a wrap
  AST_WRAP_TOGGLE: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    wrap[1] && !ctrl_wr[1] |=> ctrl_q[1].toggle_latch != $past(ctrl_q[1].toggle_latch))
    else $error("latch did not toggle on wrap");
  AST_SHADOW_LAG: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    trig && !ctrl_wr[1] |=> !trig || wrap[1])
    else $error("shadow mismatch lasted");
  AST_SW_NO_TRIG: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    ctrl_wr[1] |=> !trig)
    else $error("software latch write made a trigger");
  AST_OUT_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    !ctrl_q[1].toggle_oe |-> toggle_output_pin)
    else $error("output pin not high when disabled");
  AST_RUN_STOP: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    !ctrl_q[1].run && !cnt_wr[1] && !cnt_core_reload |=> $stable(aux_cnt[1]))
    else $error("core counted while stopped");
  AST_CPU_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    cnt_wr[1] |=> aux_cnt[1] == $past(avs_writedata[31:16]))
    else $error("cpu write lost");
  AST_TICK_RATE: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    tick |=> !tick [*3] ##1 tick)
    else $error("tick not every fourth clock");
  AST_UP_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    step[1] && !dir_down[1] && aux_cnt[1] == `GPTC_CNT_MAX && !cnt_wr[1]
    && !cnt_core_reload |=> aux_cnt[1] == `GPTC_CNT_ZERO)
    else $error("overflow did not wrap to zero");
endmodule // gptc_core
`default_nettype wire

/* gptc_pin_model.sv */
// Purpose: far-side model of the gate/count and up/down pins of the three timers
// Assumes: one clock; the bench sets levels and asks for count bursts on the core pin
// Notes:   pulses stay high and low 8 clocks each, so the pin synchroniser never misses one
`default_nettype none
module gptc_pin_model
  import gptc_pkg::*;
(
  // clock
  input  wire logic                    clk_sys,
  // levels and bursts asked by the bench
  input  wire logic [2:0]              gate_lvl,
  input  wire logic [2:0]              dir_lvl,
  input  wire logic [3:0]              n_pulse,
  input  wire logic                    go,
  // pins toward the timer
  output gptc_pkg::gptc_pins_type      pins [3],
  output logic                         busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left_q = 4'h0;
  logic [2:0] ph_q   = 3'h0;
  logic       hi_q   = 1'h0;

  // burst of whole pulses; a pulse only ends after its low-going edge
  always_ff @(posedge clk_sys) begin
    if (go && left_q == 4'h0) begin
      left_q <= n_pulse;
      ph_q   <= 3'h0;
      hi_q   <= 1'h0;
    end else if (left_q != 4'h0) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7) begin
        hi_q <= !hi_q;
        if (hi_q) begin
          left_q <= left_q - 4'h1;
        end
      end
    end
  end

  assign busy = (left_q != 4'h0);

  // pin levels; only the core pin carries count pulses
  for (genvar g = 0; g < 3; g++) begin : g_pin
    assign pins[g].gate_count = gate_lvl[g] ^ ((g == 1) && hi_q);
    assign pins[g].ext_updown = dir_lvl[g];
  end
endmodule // gptc_pin_model
`default_nettype wire

/* gp_timer_core_control_bench.sv */
// Purpose: self-checking bench of the core timer control block
// Assumes: avalon-mm master tasks, pin model on the far side, 40 MHz clock
// Notes:   tick phase is unknown, so checks of ticking counts test direction and motion only
`include "gptc_consts.svh"
`default_nettype none
module gp_timer_core_control_bench
  import gptc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] A_CORE = `GPTC_OFS_CORE_CTRL;
  localparam logic [3:0] A_AUXA = `GPTC_OFS_AUX_A_CTRL;
  localparam logic [3:0] A_AUXB = `GPTC_OFS_AUX_B_CTRL;
  logic          clk_sys = 1'h0;
  logic          reset_n = 1'h0;
  logic [3:0]    avs_address = 4'h0;
  logic          avs_read = 1'h0;
  logic          avs_write = 1'h0;
  logic [31:0]   avs_writedata = 32'h0;
  logic [3:0]    avs_byteenable = 4'h0;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic [1:0]    avs_response;
  gptc_pins_type pins [3];
  logic          toggle_output_pin;
  logic          aux_a_trigger;
  logic          aux_b_trigger;
  logic [2:0]    gate_lvl = 3'h0;
  logic [2:0]    dir_lvl = 3'h0;
  logic [3:0]    n_pulse = 4'h0;
  logic          go = 1'h0;
  logic          busy;
  logic [31:0]   rd_q;
  logic [1:0]    rsp_q;
  logic [15:0]   c0;
  logic [15:0]   c1;
  logic [3:0]    up;
  logic [11:0]   lt_ctl [4] = '{12'h180, 12'h100, 12'h080, 12'h000};
  logic [3:0]    lt_pin = 4'hD;
  logic [11:0]   gm_ctl [6] = '{12'h018, 12'h018, 12'h01A, 12'h01A, 12'h019, 12'h01B};
  logic [5:0]    gm_gate = 6'h26;
  logic [5:0]    gm_move = 6'h05;
  int            error_cnt = 0;
  int            check_count = 0;
  int            trig_cnt = 0;
  int            t0;

  gptc_core dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .pins(pins), .toggle_output_pin(toggle_output_pin),
    .aux_a_trigger(aux_a_trigger), .aux_b_trigger(aux_b_trigger));

  gptc_pin_model pin_u (
    .clk_sys(clk_sys), .gate_lvl(gate_lvl), .dir_lvl(dir_lvl), .n_pulse(n_pulse),
    .go(go), .pins(pins), .busy(busy));

  // 25 ns clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // trigger pulses counted mid-cycle; a stuck level would count many times
  always @(negedge clk_sys) begin
    if (aux_a_trigger === 1'h1) trig_cnt++;
    if (aux_a_trigger !== aux_b_trigger) begin
      error_cnt++;
      $display("[FAIL] trigger pair expected equal seen %b %b", aux_a_trigger, aux_b_trigger);
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    chk("waitrequest", 0, avs_waitrequest);
    rd_q  = avs_readdata;
    rsp_q = avs_response;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask

  task automatic run_for(input logic [3:0] a, input logic [11:0] ctl, input logic [15:0] st,
                         input int n, output logic [15:0] cnt);
    bus(1'h1, a, {st, 4'h0, ctl}, 4'hF);
    repeat (n) @(posedge clk_sys);
    bus(1'h0, a, 32'h0, 4'hF);
    cnt = rd_q[31:16];
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog far beyond the thousand or so cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    $display("[FAIL] watchdog expected done seen timeout");
    results();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    bus(1'h0, A_CORE, 32'h0, 4'hF);
    chk("core reset", 32'h0, rd_q);
    chk("pin idle", 1, toggle_output_pin);
    for (int i = 0; i < 3; i++) begin
      bus(1'h1, {i[1:0], 2'h0}, {16'hA5C0 + i[15:0], 16'h0}, 4'hF);
      bus(1'h0, {i[1:0], 2'h0}, 32'h0, 4'hF);
      chk("count rw", {16'hA5C0 + i[15:0], 16'h0}, rd_q);
    end
    // cpu write landing in three of the four tick phases of a running timer
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, A_CORE, {16'h1000, 4'h0, 12'h010}, 4'hF);
      repeat (i) @(posedge clk_sys);
      bus(1'h1, A_CORE, {16'h5555, 4'h0, 12'h000}, 4'hF);
      bus(1'h0, A_CORE, 32'h0, 4'hF);
      chk("write prio", 32'h5555_0000, rd_q);
    end
    $display("test access done");
    t0 = trig_cnt;
    run_for(A_CORE, 12'h010, 16'hFFFD, 40, c1);
    chk("up wrap", 1, c1 < 16'h0010);
    chk("latch up", 12'h090, rd_q[11:0]);
    chk("trigger up", t0 + 1, trig_cnt);
    run_for(A_CORE, 12'h030, 16'h0002, 40, c1);
    chk("down wrap", 1, c1 > 16'hFFF0);
    chk("latch down", 12'h0B0, rd_q[11:0]);
    chk("trigger down", t0 + 2, trig_cnt);
    // software latch writes move both latches, so no trigger
    t0 = trig_cnt;
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, A_CORE, {20'h0, lt_ctl[i]}, 4'h3);
      repeat (2) @(posedge clk_sys);
      chk("toggle pin", lt_pin[i], toggle_output_pin);
      bus(1'h0, A_CORE, 32'h0, 4'hF);
      chk("latch write", lt_ctl[i], rd_q[11:0]);
    end
    chk("no trigger", t0, trig_cnt);
    run_for(A_CORE, 12'h000, 16'h4000, 40, c1);
    chk("stopped", 16'h4000, c1);
    $display("test latch done");
    // external direction pin, inverted by the software bit
    for (int i = 0; i < 4; i++) begin
      dir_lvl[1] <= i[1];
      repeat (4) @(posedge clk_sys);
      run_for(A_CORE, 12'h050 | {6'h0, i[0], 5'h0}, 16'h8000, 40, c1);
      up[i] = c1 > 16'h8000;
    end
    chk("sw invert", !up[0], up[1]);
    chk("pin dir", !up[0], up[2]);
    chk("both invert", up[0], up[3]);
    run_for(A_CORE, 12'h010, 16'h8000, 20, c0);
    bus(1'h1, A_CORE, {20'h0, 12'h030}, 4'h3);
    repeat (80) @(posedge clk_sys);
    bus(1'h0, A_CORE, 32'h0, 4'hF);
    chk("reverse running", 1, rd_q[31:16] < c0);
    $display("test direction done");
    // gated modes and encoder modes with still pins
    for (int i = 0; i < 6; i++) begin
      gate_lvl[1] <= gm_gate[i];
      repeat (4) @(posedge clk_sys);
      run_for(A_CORE, gm_ctl[i], 16'h2000, 40, c1);
      chk("gated move", gm_move[i], c1 != 16'h2000);
    end
    gate_lvl[1] <= 1'h0;
    run_for(A_CORE, 12'h012, 16'h0100, 4, c1);
    @(posedge clk_sys);
    go      <= 1'h1;
    n_pulse <= 4'h3;
    @(posedge clk_sys);
    go <= 1'h0;
    repeat (2) @(posedge clk_sys);
    for (int n = 0; n < 200 && busy; n++) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    bus(1'h0, A_CORE, 32'h0, 4'hF);
    chk("counted", 16'h0103, rd_q[31:16]);
    $display("test modes done");
    // aux a counts latch triggers, aux b reloads the core, then aux a captures
    bus(1'h1, A_AUXA, {16'h1000, 4'h0, 12'h410}, 4'hF);
    bus(1'h1, A_AUXB, {16'h1234, 4'h0, 12'h800}, 4'hF);
    run_for(A_CORE, 12'h010, 16'hFFFE, 40, c1);
    chk("reload", 1, (c1 - 16'h1234) < 16'h0010);
    bus(1'h0, A_AUXA, 32'h0, 4'hF);
    chk("concat", 32'h1001_0410, rd_q);
    bus(1'h1, A_CORE, {16'h4321, 4'h0, 12'h000}, 4'hF);
    bus(1'h1, A_AUXA, {16'h0000, 4'h0, 12'hC00}, 4'hF);
    gate_lvl[0] <= 1'h1;
    repeat (6) @(posedge clk_sys);
    bus(1'h0, A_AUXA, 32'h0, 4'hF);
    chk("capture", 32'h4321_0C00, rd_q);
    $display("test link done");
    // remote run of aux a only
    bus(1'h1, A_AUXA, {16'h1000, 4'h0, 12'h200}, 4'hF);
    bus(1'h1, A_AUXB, {16'h1000, 4'h0, 12'h000}, 4'hF);
    run_for(A_CORE, 12'h010, 16'h0000, 40, c1);
    bus(1'h0, A_AUXA, 32'h0, 4'hF);
    chk("remote on", 1, rd_q[31:16] != 16'h1000);
    bus(1'h0, A_AUXB, 32'h0, 4'hF);
    chk("no remote", 32'h1000_0000, rd_q);
    bus(1'h1, A_CORE, 32'h0, 4'hF);
    bus(1'h0, A_AUXA, 32'h0, 4'hF);
    c0 = rd_q[31:16];
    repeat (40) @(posedge clk_sys);
    bus(1'h0, A_AUXA, 32'h0, 4'hF);
    chk("remote off", c0, rd_q[31:16]);
    bus(1'h0, 4'hC, 32'h0, 4'hF);
    chk("unmapped rsp", 2'h2, rsp_q);
    chk("unmapped data", 32'h0, rd_q);
    $display("test remote done");
    results();
  end
endmodule // gp_timer_core_control_bench
`default_nettype wire
